// ===== logic/epa_pkg.sv
/*
 * epa_pkg: constants for the emulated partner ability register.
 * Assumes a single 200 MHz system clock and one register read port.
 */
package epa_pkg;
	// bit positions of the partner ability word
	localparam int EPA_BIT_100FD  = 8;
	localparam int EPA_BIT_100HD  = 7;
	localparam int EPA_BIT_10FD   = 6;
	localparam int EPA_BIT_10HD   = 5;
	localparam int EPA_BIT_SYM    = 10;
	localparam int EPA_BIT_ASYM   = 11;
	localparam int EPA_BIT_T4     = 9;
	localparam int EPA_BIT_RFAULT = 13;
	localparam int EPA_BIT_ACK    = 14;
	localparam int EPA_BIT_NP     = 15;
	// advertisement register pause positions
	localparam int EPA_ADV_SYM    = 10;
	localparam int EPA_ADV_ASYM   = 11;
	// selector code, ieee 802.3
	localparam logic [4:0]  EPA_SELECTOR   = 5'h01;
	// speed/duplex nibbles for bits 8..5
	localparam logic [3:0]  EPA_AB_10FD    = 4'h2;
	localparam logic [3:0]  EPA_AB_100FD   = 4'h8;
	localparam logic [3:0]  EPA_AB_10HD    = 4'h1;
	localparam logic [3:0]  EPA_AB_100HD   = 4'h4;
	// reset values; ack stays set so the fixed bits never glitch
	localparam logic [15:0] EPA_WORD_RST   = 16'h4001;
	localparam logic        EPA_STRAP_RST  = 1'h0;
	localparam logic [1:0]  EPA_ARM_RST    = 2'h0;
	// last wait count before strap capture, synchronisers filled by then
	localparam logic [1:0]  EPA_ARM_LAST   = 2'h1;

	typedef enum logic [1:0] {
		EPA_ST_WAIT,
		EPA_ST_CAPTURE,
		EPA_ST_HOLD
	} epa_strap_st_t;
endpackage

// ===== logic/epa_sync.sv
/*
 * epa_sync: two flip-flop synchroniser for one level.
 * Assumes the input is asynchronous to i_clk.
 */
`timescale 1ns/1ps
module epa_sync
	import epa_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_resetn,
	input  wire logic i_async,
	output logic      o_sync
);
	typedef struct packed {
		logic meta;
		logic sync;
	} epa_sync_st_t;

	epa_sync_st_t s_r;
	epa_sync_st_t s_nxt;

	// first stage feeds only the second
	always_comb begin
		s_nxt      = s_r;
		s_nxt.meta = i_async;
		s_nxt.sync = s_r.meta;
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_sync = s_r.sync;
endmodule

// ===== logic/epa_strap.sv
/*
 * epa_strap: captures the two configuration straps once after reset.
 * Assumes straps are already synchronised and stable around release.
 */
`timescale 1ns/1ps
module epa_strap
	import epa_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_resetn,
	input  wire logic i_duplex_pol,
	input  wire logic i_speed,
	output logic      o_duplex_pol,
	output logic      o_speed,
	output logic      o_valid
);
	typedef struct packed {
		epa_strap_st_t st;
		logic [1:0]    arm;
		logic          pol;
		logic          spd;
	} epa_strap_s_t;

	epa_strap_s_t s_r;
	epa_strap_s_t s_nxt;

	// one capture after release, then frozen until next reset
	always_comb begin
		s_nxt = s_r;
		case (s_r.st)
			EPA_ST_WAIT: begin
				// sync outputs still hold reset zeros for two edges
				s_nxt.arm = s_r.arm + 2'h1;
				if (s_r.arm == EPA_ARM_LAST) begin
					s_nxt.st = EPA_ST_CAPTURE;
				end
			end
			EPA_ST_CAPTURE: begin
				s_nxt.pol = i_duplex_pol; // see R11
				s_nxt.spd = i_speed;      // see R11
				s_nxt.st  = EPA_ST_HOLD;
			end
			EPA_ST_HOLD: begin
				s_nxt.st = EPA_ST_HOLD;   // see R11
			end
			default: begin
				s_nxt.st = EPA_ST_WAIT;
			end
		endcase
	end

	// reset loads constants only; straps are taken by the clocked path
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_r.st  <= EPA_ST_WAIT;
			s_r.arm <= EPA_ARM_RST;
			s_r.pol <= EPA_STRAP_RST;
			s_r.spd <= EPA_STRAP_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_duplex_pol = s_r.pol;
	assign o_speed      = s_r.spd;
	assign o_valid      = (s_r.st == EPA_ST_HOLD);
endmodule

// ===== logic/epa_partner_ability.sv
/*
 * epa_partner_ability: read-only emulated link partner ability register.
 * Assumes the advertisement word and autoneg result come from logic on
 * i_clk; the duplex pin and straps are asynchronous and are synchronised.
 */
// Summary of operation
// R1: bit 8 reports partner 100BASE-X full duplex ability.
// R2: bit 7 reports partner 100BASE-X half duplex ability.
// R3: bit 6 reports partner 10BASE-T full duplex ability.
// R4: bit 5 reports partner 10BASE-T half duplex ability.
// R5: bits 4:0 always read 00001, the 802.3 selector.
// R6: 16 bits for management reads, 32 bits zero-padded otherwise.
// R7: no next page, ack set, no remote fault, no T4.
// R8: partner pause bits follow our own advertised pause bits.
// R9: pause map 00->00, sym->10, asym->11, both->01 onto bits 10,11.
// R10: abilities from duplex pin, polarity strap, speed strap, autoneg.
// R11: straps captured once when reset releases, then held.
// R12: pin equals polarity: 0010 at speed 0, 1000 at speed 1.
// R13: pin differs: 0001 at speed 0, 0100 at speed 1.
// R14: writes are ignored; every field is computed and read-only.
`timescale 1ns/1ps
module epa_partner_ability
	import epa_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_duplex_pin,
	input  wire logic        i_duplex_pol_strap,
	input  wire logic        i_speed_strap,
	input  wire logic [15:0] i_virtual_phy_advertisement_reg,
	input  wire logic        i_an_fail,
	input  wire logic        i_wr_en,
	input  wire logic [31:0] i_wr_data,
	output logic [15:0]      o_mii_rdata,
	output logic [31:0]      o_rdata
);
	typedef struct packed {
		logic [15:0] word;
	} epa_state_t;

	epa_state_t s_r;
	epa_state_t s_nxt;

	logic       duplex_s;
	logic       pol_s;
	logic       speed_s;
	logic       pol_l;
	logic       speed_l;
	logic       strap_ok;
	logic [3:0] ability;
	logic [1:0] pause;

	// pin and straps come from outside the clock domain
	epa_sync u_sync_dup (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_async  (i_duplex_pin),
		.o_sync   (duplex_s)
	);

	epa_sync u_sync_pol (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_async  (i_duplex_pol_strap),
		.o_sync   (pol_s)
	);

	epa_sync u_sync_spd (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_async  (i_speed_strap),
		.o_sync   (speed_s)
	);

	// capture waits two cycles so the synchronisers have filled
	epa_strap u_strap (
		.i_clk        (i_clk),
		.i_resetn     (i_resetn),
		.i_duplex_pol (pol_s),
		.i_speed      (speed_s),
		.o_duplex_pol (pol_l),
		.o_speed      (speed_l),
		.o_valid      (strap_ok)
	);

	// speed/duplex nibble for bits 8..5
	always_comb begin
		if (duplex_s == pol_l) begin
			ability = speed_l ? EPA_AB_100FD : EPA_AB_10FD;  // see R12
		end else begin
			ability = speed_l ? EPA_AB_100HD : EPA_AB_10HD;  // see R13
		end
		// failed negotiation means no common ability is offered
		if (i_an_fail || !strap_ok) begin
			ability = 4'h0;                                  // see R10
		end
	end

	// partner always accepts the pause request we advertised
	always_comb begin
		case ({i_virtual_phy_advertisement_reg[EPA_ADV_ASYM],
			i_virtual_phy_advertisement_reg[EPA_ADV_SYM]})
			2'h1: begin
				pause = 2'h1;  // see R8, see R9: sym only
			end
			2'h2: begin
				pause = 2'h3;  // see R9: asym only
			end
			2'h3: begin
				pause = 2'h2;  // see R9: both
			end
			default: begin
				pause = 2'h0;  // see R9: neither
			end
		endcase
	end

	// assemble the word; writes never reach it
	always_comb begin
		s_nxt = s_r;
		s_nxt.word = 16'h0000;
		s_nxt.word[4:0] = EPA_SELECTOR;                   // see R5
		s_nxt.word[EPA_BIT_10HD]  = ability[0];           // see R4
		s_nxt.word[EPA_BIT_10FD]  = ability[1];           // see R3
		s_nxt.word[EPA_BIT_100HD] = ability[2];           // see R2
		s_nxt.word[EPA_BIT_100FD] = ability[3];           // see R1
		s_nxt.word[EPA_BIT_T4]    = 1'h0;                 // see R7
		s_nxt.word[EPA_BIT_SYM]   = pause[0];             // see R9
		s_nxt.word[EPA_BIT_ASYM]  = pause[1];             // see R9
		s_nxt.word[EPA_BIT_RFAULT] = 1'h0;                // see R7
		s_nxt.word[EPA_BIT_ACK]   = 1'h1;                 // see R7
		s_nxt.word[EPA_BIT_NP]    = 1'h0;                 // see R7
	end

	// write port exists for bus symmetry only
	logic wr_unused;
	assign wr_unused = i_wr_en & (|i_wr_data);            // see R14

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_r.word <= EPA_WORD_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs from the flop; upper half of the wide view reads zero
	always_comb begin
		o_mii_rdata = s_r.word;                           // see R6
		o_rdata     = {16'h0000, s_r.word};               // see R6
	end
endmodule

// ===== tb/epa_partner_ability_sva.sv
/*
 * epa_partner_ability_sva: port checks for the ability register.
 * Assumes it is bound to every epa_partner_ability instance.
 */
`timescale 1ns/1ps
module epa_partner_ability_sva (
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_duplex_pin,
	input  wire logic        i_an_fail,
	input  wire logic        i_wr_en,
	input  wire logic [15:0] i_virtual_phy_advertisement_reg,
	input  wire logic [15:0] o_mii_rdata,
	input  wire logic [31:0] o_rdata
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	// shorthand for the ability nibble and our own pause pair
	wire logic [3:0] ab  = o_mii_rdata[8:5];
	wire logic [1:0] adv = i_virtual_phy_advertisement_reg[11:10];

	chk_sel_code: assert property (o_mii_rdata[4:0] == 5'h01)
		else $error("selector field wrong");
	chk_pad_zero: assert property (o_rdata == {16'h0000, o_mii_rdata})
		else $error("wide view differs from serial view");
	chk_fixed_bits: assert property (o_mii_rdata[15:12] == 4'h4
		&& !o_mii_rdata[9]) else $error("fixed partner bits wrong");
	// pause pair lands one edge after the advertisement settles
	chk_pause_map: assert property ($stable(adv) |->
		o_mii_rdata[11] == adv[1] && o_mii_rdata[10] == (adv[0] ^ adv[1]))
		else $error("partner pause bits wrong");
	chk_fail_clear: assert property (i_an_fail |=> ab == 4'h0)
		else $error("abilities not cleared on failed negotiation");
	chk_one_ability: assert property ($onehot0(ab))
		else $error("more than one ability advertised");
	// a pin flip must swap full and half within four edges
	chk_pin_swap: assert property ($changed(i_duplex_pin) && ab != 4'h0
		##1 ($stable(i_duplex_pin) && !i_an_fail)[*3] |=> ab != $past(ab, 4))
		else $error("duplex pin change not reflected");
	chk_write_quiet: assert property ((i_wr_en && $stable(adv)
		&& $stable(i_duplex_pin) && !i_an_fail)[*4] |=> $stable(o_mii_rdata))
		else $error("write disturbed the register");

	cover property (i_an_fail);
	cover property ($changed(i_duplex_pin) && ab != 4'h0);
	cover property (adv == 2'b11);
	cover property (i_wr_en);
endmodule
bind epa_partner_ability epa_partner_ability_sva chk (.i_clk, .i_resetn,
	.i_duplex_pin, .i_an_fail, .i_wr_en, .i_virtual_phy_advertisement_reg,
	.o_mii_rdata, .o_rdata);

// ===== tb/epa_reader.sv
/*
 * epa_reader: management-station reader model for the ability register.
 * Assumes reads are asked for one cycle, set up at a falling edge.
 */
`timescale 1ns/1ps
module epa_reader (
	input  wire logic        i_clk,
	input  wire logic        i_rd,
	input  wire logic [15:0] i_mii_rdata,
	input  wire logic [31:0] i_rdata,
	output logic [15:0]      o_mii_word,
	output logic [31:0]      o_word
);
	// both views from one edge, so they can be held against each other
	always_ff @(posedge i_clk) begin
		if (i_rd) begin
			o_mii_word <= i_mii_rdata;
			o_word     <= i_rdata;
		end
	end
endmodule

// ===== tb/testbench.sv
/*
 * testbench: scenarios for the emulated partner ability register.
 * Assumes inputs change at falling edges; reader model samples words.
 */
`timescale 1ns/1ps
module testbench;
	logic        clk = 0, rstn = 0, pin = 0, pol = 0, spd = 0;
	logic        fail = 0, we = 0, rd = 0;
	logic [15:0] adv = 16'h0000;
	logic [31:0] wd = 32'h0000_0000;
	logic [15:0] mii, mw;
	logic [31:0] rdata, w32;
	int          bad_count = 0;
	int          n_checks = 0;

	always #2.5 clk = ~clk;

	epa_partner_ability dut (.i_clk(clk), .i_resetn(rstn),
		.i_duplex_pin(pin), .i_duplex_pol_strap(pol), .i_speed_strap(spd),
		.i_virtual_phy_advertisement_reg(adv), .i_an_fail(fail),
		.i_wr_en(we), .i_wr_data(wd), .o_mii_rdata(mii), .o_rdata(rdata));
	epa_reader rdr (.i_clk(clk), .i_rd(rd), .i_mii_rdata(mii),
		.i_rdata(rdata), .o_mii_word(mw), .o_word(w32));

	task automatic tick(int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one read cycle, then the whole word against the expected layout
	task automatic rd_chk(logic [3:0] nib);
		logic [15:0] e;
		e = {4'h4, adv[11], adv[10] ^ adv[11], 1'h0, nib, 5'h01};
		rd = 1;
		tick(1);
		rd = 0;
		chk({16'h0, mw}, {16'h0, e});
		chk(w32, {16'h0000, e});
	endtask
	// straps are set up while reset is held, so they are captured on release
	task automatic do_reset(logic p, logic s, logic d);
		rstn = 0;
		pol = p;
		spd = s;
		pin = d;
		tick(2);
		chk({16'h0, mii}, 32'h0000_4001);
		rstn = 1;
		tick(8);
	endtask
	task automatic t_straps;
		logic [2:0] c [4] = '{3'b000, 3'b111, 3'b001, 3'b110};
		logic [3:0] e [4] = '{4'h2, 4'h8, 4'h1, 4'h4};
		for (int i = 0; i < 4; i++) begin
			do_reset(c[i][2], c[i][1], c[i][0]);
			rd_chk(e[i]);
		end
	endtask
	task automatic t_hold;
		pol = 0;
		spd = 0;
		tick(6);
		rd_chk(4'h4);
	endtask
	task automatic t_pin;
		pin = 1;
		tick(5);
		rd_chk(4'h8);
	endtask
	task automatic t_pause;
		for (int i = 0; i < 4; i++) begin
			adv = {4'h0, 2'(i), 10'h000};
			tick(2);
			rd_chk(4'h8);
		end
	endtask
	task automatic t_fail;
		fail = 1;
		tick(2);
		rd_chk(4'h0);
		fail = 0;
		tick(2);
		rd_chk(4'h8);
	endtask
	// writes of all ones must leave every field as computed
	task automatic t_write;
		we = 1;
		wd = 32'hFFFF_FFFF;
		tick(6);
		rd_chk(4'h8);
		we = 0;
	endtask
	task automatic conclude;
		if (bad_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// watchdog: the run needs well under a microsecond
	initial begin
		#5000;
		bad_count++;
		conclude();
	end
	initial begin
		t_straps();
		t_hold();
		t_pin();
		t_pause();
		t_fail();
		t_write();
		conclude();
	end
endmodule
